// >>> hdl/umc_pkg.sv
// Purpose: constants and types of the serial interface mode and clock control
// Assumes: registers are 8 bits wide, each in the low byte of a 32-bit word
// Notes: pin 0 is data in or SDA, pin 1 data out, pin 2 clock or SCL
package umc_pkg;

   // register byte offsets on the bus
   localparam logic [7:0] UMC_OFF_CTRL = 8'h00;
   localparam logic [7:0] UMC_OFF_PINPOS = 8'h04;
   localparam logic [7:0] UMC_OFF_SHIFT = 8'h08;
   localparam logic [7:0] UMC_OFF_STATUS = 8'h0C;
   localparam logic [7:0] UMC_OFF_PA_OUT = 8'h10;
   localparam logic [7:0] UMC_OFF_PA_DIR = 8'h14;
   localparam logic [7:0] UMC_OFF_PB_OUT = 8'h18;
   localparam logic [7:0] UMC_OFF_PB_DIR = 8'h1C;

   // values after reset, and the counter maximum
   localparam logic [7:0] UMC_RST_BYTE = 8'h00;
   localparam logic [3:0] UMC_RST_CNT = 4'h0;
   localparam logic [3:0] UMC_CNT_MAX = 4'hF;

   // field positions
   localparam int UMC_CTRL_TGL = 0;
   localparam int UMC_CTRL_CLK = 1;
   localparam int UMC_STAT_SIF = 7;
   localparam int UMC_STAT_OIF = 6;
   localparam int UMC_STAT_PIF = 5;
   localparam int UMC_STAT_DC = 4;
   localparam int UMC_PIN_DATA = 0;
   localparam int UMC_PIN_DOUT = 1;
   localparam int UMC_PIN_SCL = 2;

   // port index chosen by the pin position bit
   localparam int UMC_PORT_B = 0;
   localparam int UMC_PORT_A = 1;

   localparam logic [1:0] UMC_RESP_OKAY = 2'h0;
   localparam logic [1:0] UMC_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      UMC_WM_OFF = 2'b00,
      UMC_WM_THREE = 2'b01,
      UMC_WM_TWO = 2'b10,
      UMC_WM_TWO_OVF = 2'b11
   } umc_wire_mode_t;

   typedef enum logic [1:0] {
      UMC_CS_SOFT = 2'b00,
      UMC_CS_TIMER = 2'b01,
      UMC_CS_EXT_POS = 2'b10,
      UMC_CS_EXT_NEG = 2'b11
   } umc_clk_src_t;

   // drive of one 8-bit port: level, enable, pull-up enable
   typedef struct packed {
      logic [7:0] dout;
      logic [7:0] oe;
      logic [7:0] pull;
   } umc_port_drv_t;

endpackage : umc_pkg

// >>> hdl/umc_ctrl.sv
// Purpose: wire mode, clock source and pin control of the serial interface
// Assumes: one clock sys_clk, synchronous active high reset sys_rst
// Notes: pins pass two flops; serial clock edges are found on sys_clk
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

// Function
// - wire mode affects outputs and start and stop detect, inputs always
// - mode off: no outputs, hold, start detect
// - three-wire: data out replaces port bit
// - two-wire: open-drain pins enabled by direction
// - SDA low when shift msb or port zero
// - SCL low when port zero or held
// - start condition holds SCL until flag cleared
// - two-wire forces SDA and SCL pull-ups off, inputs unchanged
// - mode 11 also holds SCL on overflow
// - external clock: output changes opposite edge
// - soft or timer clock: latch transparent
// - soft source clocks only on strobe write
// - strobe shifts in previously sampled input
// - external: rising for 10, falling for 11
// - external counter: both edges or toggle strobe
// - toggle strobe inverts clock port bit
// - pin position bits 7:1 read zero
// - position bit selects port B or A
// - overflow flag set on wrap, write-one clear
// - start flag set on start, write-one clear
// - data out from shift msb through latch
module umc_ctrl
   import umc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic tc0_match,
   input wire logic [7:0] pa_in,
   input wire logic [7:0] pb_in,
   output umc_port_drv_t pa_drv,
   output umc_port_drv_t pb_drv
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   umc_wire_mode_t wm_q;
   umc_clk_src_t cs_q;
   logic [1:0] ie_q;
   logic clk_sel_q;
   logic pos_q;
   logic [7:0] sr_q;
   logic [3:0] cnt_q;
   logic sif_q;
   logic oif_q;
   logic pif_q;
   logic latch_q;
   logic [1:0][7:0] pout_q;
   logic [1:0][7:0] pdir_q;
   logic [1:0][7:0] sync1_q;
   logic [1:0][7:0] sync2_q;
   logic scl_p_q;
   logic sda_p_q;
   umc_port_drv_t [1:0] drv_d;
   umc_port_drv_t [1:0] drv_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [7:0] rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // bus write decode
   wire wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
   wire wr_b0 = wr_go & s_axi_wstrb[0];
   wire [7:0] wd = s_axi_wdata[7:0];
   wire wr_ctrl = wr_b0 & (s_axi_awaddr == UMC_OFF_CTRL);
   wire wr_pp = wr_b0 & (s_axi_awaddr == UMC_OFF_PINPOS);
   wire wr_sr = wr_b0 & (s_axi_awaddr == UMC_OFF_SHIFT);
   wire wr_stat = wr_b0 & (s_axi_awaddr == UMC_OFF_STATUS);
   wire wr_pa_out = wr_b0 & (s_axi_awaddr == UMC_OFF_PA_OUT);
   wire wr_pa_dir = wr_b0 & (s_axi_awaddr == UMC_OFF_PA_DIR);
   wire wr_pb_out = wr_b0 & (s_axi_awaddr == UMC_OFF_PB_OUT);
   wire wr_pb_dir = wr_b0 & (s_axi_awaddr == UMC_OFF_PB_DIR);
   wire wr_map = (s_axi_awaddr[7:5] == 3'h0) & (s_axi_awaddr[1:0] == 2'h0);

   assign s_axi_awready = s_axi_wvalid & ~bvalid_q;
   assign s_axi_wready = s_axi_awvalid & ~bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers, two flops per pin of both ports
   genvar gb;
   generate
      for (gb = 0; gb < 8; gb++) begin : g_sync
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               sync1_q[UMC_PORT_A][gb] <= 1'b0;
               sync1_q[UMC_PORT_B][gb] <= 1'b0;
               sync2_q[UMC_PORT_A][gb] <= 1'b0;
               sync2_q[UMC_PORT_B][gb] <= 1'b0;
            end else begin
               sync1_q[UMC_PORT_A][gb] <= pa_in[gb];
               sync1_q[UMC_PORT_B][gb] <= pb_in[gb];
               sync2_q[UMC_PORT_A][gb] <= sync1_q[UMC_PORT_A][gb];
               sync2_q[UMC_PORT_B][gb] <= sync1_q[UMC_PORT_B][gb];
            end
         end
      end
   endgenerate

   // inputs read in every wire mode
   wire di_s = sync2_q[pos_q][UMC_PIN_DATA];
   wire scl_s = sync2_q[pos_q][UMC_PIN_SCL];
   wire scl_rise = scl_s & ~scl_p_q;
   wire scl_fall = ~scl_s & scl_p_q;
   wire sda_rise = di_s & ~sda_p_q;
   wire sda_fall = ~di_s & sda_p_q;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         scl_p_q <= 1'b0;
         sda_p_q <= 1'b0;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= di_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock source selection for shift register and counter
   wire two_wire = wm_q[1];
   wire sh_soft = wr_ctrl & wd[UMC_CTRL_CLK] &
      (wd[3:2] == UMC_CS_SOFT);
   wire sh_timer = (cs_q == UMC_CS_TIMER) & tc0_match;
   wire sh_ext = cs_q[1] & (cs_q[0] ? scl_fall : scl_rise);
   wire shift_en = sh_soft | sh_timer | sh_ext;
   wire cnt_ext = cs_q[1] & ~clk_sel_q & (scl_rise | scl_fall);
   wire cnt_tgl = wr_ctrl & wd[3] & wd[UMC_CTRL_CLK] &
      wd[UMC_CTRL_TGL];
   wire cnt_en = sh_soft | sh_timer | cnt_ext | cnt_tgl;
   wire cnt_wrap = cnt_en & (cnt_q == UMC_CNT_MAX) & ~wr_stat;
   wire start_det = two_wire & scl_s & sda_fall;
   wire stop_det = two_wire & scl_s & sda_rise;
   wire tgl_wr = wr_ctrl & wd[UMC_CTRL_TGL];

   ////////////////////////////////////////////////////////////////////////////
   // control and pin position registers
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ie_q <= UMC_RST_BYTE[7:6];
         wm_q <= UMC_WM_OFF;
         cs_q <= UMC_CS_SOFT;
         clk_sel_q <= 1'b0;
         pos_q <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ie_q <= wd[7:6];
            wm_q <= umc_wire_mode_t'(wd[5:4]);
            cs_q <= umc_clk_src_t'(wd[3:2]);
            clk_sel_q <= wd[UMC_CTRL_CLK];
         end
         if (wr_pp) begin
            pos_q <= wd[0];
         end
      end
   end

   // shift register: a bus write wins over a shift in the same cycle
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sr_q <= UMC_RST_BYTE;
      end else if (wr_sr) begin
         sr_q <= wd;
      end else if (shift_en) begin
         sr_q <= {sr_q[6:0], di_s};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_q <= UMC_RST_CNT;
      end else if (wr_stat) begin
         cnt_q <= wd[3:0];
      end else if (cnt_en) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   // flags: a start or stop set in the cycle of a clear wins; any status write blocks the overflow set
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sif_q <= 1'b0;
         oif_q <= 1'b0;
         pif_q <= 1'b0;
      end else begin
         sif_q <= start_det |
            (sif_q & ~(wr_stat & wd[UMC_STAT_SIF]));
         oif_q <= cnt_wrap |
            (oif_q & ~(wr_stat & wd[UMC_STAT_OIF]));
         pif_q <= stop_det | (pif_q & ~(wr_stat & wd[UMC_STAT_PIF]));
      end
   end

   // output latch open while the serial clock is in its first half
   wire latch_open = (scl_s == cs_q[0]);
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         latch_q <= 1'b0;
      end else if (latch_open) begin
         latch_q <= sr_q[7];
      end
   end
   wire do_bit = cs_q[1] ? latch_q : sr_q[7];

   ////////////////////////////////////////////////////////////////////////////
   // port output and direction registers
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pout_q <= '0;
         pdir_q <= '0;
      end else begin
         if (wr_pa_out) begin
            pout_q[UMC_PORT_A] <= wd;
         end
         if (wr_pb_out) begin
            pout_q[UMC_PORT_B] <= wd;
         end
         if (wr_pa_dir) begin
            pdir_q[UMC_PORT_A] <= wd;
         end
         if (wr_pb_dir) begin
            pdir_q[UMC_PORT_B] <= wd;
         end
         if (tgl_wr) begin
            pout_q[pos_q][UMC_PIN_SCL] <=
               ~pout_q[pos_q][UMC_PIN_SCL];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive
   wire scl_hold = (two_wire & sif_q) |
                   ((wm_q == UMC_WM_TWO_OVF) & oif_q);
   wire sda_coll = two_wire & (do_bit != di_s);

   always_comb begin
      for (int p = 0; p < 2; p++) begin
         drv_d[p].dout = pout_q[p];
         drv_d[p].oe = pdir_q[p];
         drv_d[p].pull = ~pdir_q[p] & pout_q[p];
         if (pos_q == p[0]) begin
            if (wm_q == UMC_WM_THREE) begin
               drv_d[p].dout[UMC_PIN_DOUT] = do_bit;
            end
            if (two_wire) begin
               drv_d[p].dout[UMC_PIN_DATA] = 1'b0;
               drv_d[p].oe[UMC_PIN_DATA] = pdir_q[p][UMC_PIN_DATA] &
                  (~do_bit | ~pout_q[p][UMC_PIN_DATA]);
               drv_d[p].dout[UMC_PIN_SCL] = 1'b0;
               drv_d[p].oe[UMC_PIN_SCL] = pdir_q[p][UMC_PIN_SCL] &
                  (~pout_q[p][UMC_PIN_SCL] | scl_hold);
               drv_d[p].pull[UMC_PIN_DATA] = 1'b0;
               drv_d[p].pull[UMC_PIN_SCL] = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         drv_q <= '0;
      end else begin
         drv_q <= drv_d;
      end
   end
   assign pa_drv = drv_q[UMC_PORT_A];
   assign pb_drv = drv_q[UMC_PORT_B];

   ////////////////////////////////////////////////////////////////////////////
   // bus write response
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         bvalid_q <= 1'b0;
         bresp_q <= UMC_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_map ? UMC_RESP_OKAY : UMC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus read
   logic [7:0] rd_val;
   wire rd_go = s_axi_arvalid & ~rvalid_q;
   wire rd_map = (s_axi_araddr[7:5] == 3'h0) & (s_axi_araddr[1:0] == 2'h0);
   wire [7:0] stat_val = {sif_q, oif_q, pif_q, sda_coll, cnt_q};

   always_comb begin
      case (s_axi_araddr)
         UMC_OFF_CTRL: rd_val = {ie_q, wm_q, cs_q, 2'b00};
         UMC_OFF_PINPOS: rd_val = {7'h00, pos_q};
         UMC_OFF_SHIFT: rd_val = sr_q;
         UMC_OFF_STATUS: rd_val = stat_val;
         UMC_OFF_PA_OUT: rd_val = pout_q[UMC_PORT_A];
         UMC_OFF_PA_DIR: rd_val = pdir_q[UMC_PORT_A];
         UMC_OFF_PB_OUT: rd_val = pout_q[UMC_PORT_B];
         UMC_OFF_PB_DIR: rd_val = pdir_q[UMC_PORT_B];
         default: rd_val = UMC_RST_BYTE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rvalid_q <= 1'b0;
         rresp_q <= UMC_RESP_OKAY;
         rdata_q <= UMC_RST_BYTE;
      end else if (rd_go) begin
         rvalid_q <= 1'b1;
         rresp_q <= rd_map ? UMC_RESP_OKAY : UMC_RESP_SLVERR;
         rdata_q <= rd_val;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = {24'h00_0000, rdata_q};

   ////////////////////////////////////////////////////////////////////////////
   // checks
   wire sel_scl_oe = drv_q[pos_q].oe[UMC_PIN_SCL];
   wire sel_pout_scl = pout_q[pos_q][UMC_PIN_SCL];
   wire sel_dir_scl = pdir_q[pos_q][UMC_PIN_SCL];

   sequence s_rd_ctrl;
      rd_go && (s_axi_araddr == UMC_OFF_CTRL);
   endsequence
   property p_strobe_zero;
      @(posedge sys_clk) disable iff (sys_rst)
      s_rd_ctrl |=> (s_axi_rdata[1:0] == 2'b00);
   endproperty
   a_strobe_zero: assert property (p_strobe_zero)
      else $error("strobe bits read back nonzero");

   property p_pinpos_zero;
      @(posedge sys_clk) disable iff (sys_rst)
      (rd_go && s_axi_araddr == UMC_OFF_PINPOS)
         |=> (s_axi_rdata[7:1] == 7'h00);
   endproperty
   a_pinpos_zero: assert property (p_pinpos_zero)
      else $error("pin position reserved bits nonzero");

   property p_ovf_set;
      @(posedge sys_clk) disable iff (sys_rst)
      (cnt_en && cnt_q == UMC_CNT_MAX && !wr_stat)
         |=> (oif_q && cnt_q == 4'h0);
   endproperty
   a_ovf_set: assert property (p_ovf_set)
      else $error("counter wrap did not set overflow flag");

   sequence s_start_held;
      two_wire && !wr_ctrl && !wr_pp && sif_q && sel_dir_scl ##1 sif_q;
   endsequence
   property p_start_hold;
      @(posedge sys_clk) disable iff (sys_rst)
      s_start_held |-> sel_scl_oe;
   endproperty
   a_start_hold: assert property (p_start_hold)
      else $error("scl not held after start condition");

   property p_off_no_start;
      @(posedge sys_clk) disable iff (sys_rst)
      (wm_q == UMC_WM_OFF && !sif_q) |=> !sif_q;
   endproperty
   a_off_no_start: assert property (p_off_no_start)
      else $error("start flag set with outputs off");

   property p_ext_shift;
      @(posedge sys_clk) disable iff (sys_rst)
      (cs_q == UMC_CS_EXT_POS && scl_rise && !wr_sr)
         |=> (sr_q == {$past(sr_q[6:0]), $past(di_s)});
   endproperty
   a_ext_shift: assert property (p_ext_shift)
      else $error("no shift on rising serial clock");

   property p_soft_idle;
      @(posedge sys_clk) disable iff (sys_rst)
      (cs_q == UMC_CS_SOFT && !wr_ctrl && !wr_sr && !wr_stat)
         |=> ($stable(sr_q) && $stable(cnt_q));
   endproperty
   a_soft_idle: assert property (p_soft_idle)
      else $error("shift or count without strobe");

   property p_toggle;
      @(posedge sys_clk) disable iff (sys_rst)
      (tgl_wr) |=> (sel_pout_scl != $past(sel_pout_scl));
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("toggle strobe did not invert clock port bit");

   property p_cnt_tgl_only;
      @(posedge sys_clk) disable iff (sys_rst)
      (cs_q[1] && clk_sel_q && !wr_ctrl && !wr_stat) |=> $stable(cnt_q);
   endproperty
   a_cnt_tgl_only: assert property (p_cnt_tgl_only)
      else $error("counter moved without toggle strobe");

   property p_ovf_hold;
      @(posedge sys_clk) disable iff (sys_rst)
      (wm_q == UMC_WM_TWO_OVF && oif_q && sel_dir_scl && !wr_ctrl && !wr_pp)
         |=> sel_scl_oe;
   endproperty
   a_ovf_hold: assert property (p_ovf_hold)
      else $error("scl not held on counter overflow");

endmodule : umc_ctrl

// >>> tb/umc_peer.sv
// Purpose: serial peer on one port, open-drain lines with bus pull-ups
// Assumes: a released line reads high through its pull-up
// Notes: peer edges follow a 160 ns link period, unrelated to sys_clk
`timescale 1ns/1ps
module umc_peer
   import umc_pkg::*;
(
   input wire umc_port_drv_t drv,
   output logic [7:0] pin
);
   // bit 2 (clock) idles low between frames
   logic [7:0] low_q = 8'h04;

   // any party pulling low wins over the pull-up
   assign pin = ~(drv.oe & ~drv.dout) & ~low_q;

   task automatic line(input int b, input logic v);
      low_q[b] <= ~v;
      #80;
   endtask : line

   // one link clock period: rise, then fall
   task automatic clk_pulse();
      line(2, 1'b1);
      line(2, 1'b0);
   endtask : clk_pulse
endmodule : umc_peer

// >>> tb/usi_mode_clock_control_tb_top.sv
// Purpose: register level tests of the serial mode and clock control
// Assumes: peers on both ports; bus master in the bench
// Notes: pin checks wait for the two-flop input synchronisers
`timescale 1ns/1ps
module usi_mode_clock_control_tb_top;
   import umc_pkg::*;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic tc0_match = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [7:0] pa_in, pb_in;
   umc_port_drv_t pa_drv, pb_drv;
   int failures = 0;
   int cmp_count = 0;
   int cyc = 0;

   umc_ctrl i_umc_ctrl (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tc0_match, .pa_in,
      .pb_in, .pa_drv, .pb_drv);
   umc_peer i_peer_a (.drv(pa_drv), .pin(pa_in));
   umc_peer i_peer_b (.drv(pb_drv), .pin(pb_in));

   always #10 sys_clk = ~sys_clk;

   ////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (failures == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cb(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask : cb

   // unmapped or unaligned offsets answer with an error
   function automatic logic [1:0] ersp(input logic [7:0] a);
      return (a > UMC_OFF_PB_DIR || a[1:0] != 2'h0) ? UMC_RESP_SLVERR
         : UMC_RESP_OKAY;
   endfunction : ersp

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge sys_clk); while (!(s_axi_awready && s_axi_wready));
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      while (!s_axi_bvalid) @(posedge sys_clk);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, ersp(a)});
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge sys_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge sys_clk);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, {24'h00_0000, e});
      chk({30'h0, s_axi_rresp}, {30'h0, ersp(a)});
   endtask : rdc

   task automatic settle();
      repeat (8) @(posedge sys_clk);
   endtask : settle

   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rdc(UMC_OFF_CTRL, 8'h00);
      rdc(UMC_OFF_STATUS, 8'h00);
      chk({8'h00, pb_drv}, 32'h0000_0000);
      rdc(8'h22, 8'h00);
      wr(8'h40, 8'hFF);
      wr(UMC_OFF_PINPOS, 8'hFE);
      rdc(UMC_OFF_PINPOS, 8'h00);
      // outputs off: port bit drives the pin, inputs still shift
      wr(UMC_OFF_PB_DIR, 8'h02);
      wr(UMC_OFF_PB_OUT, 8'h00);
      wr(UMC_OFF_SHIFT, 8'h80);
      settle();
      cb(pb_drv.dout[1], 1'b0);
      wr(UMC_OFF_CTRL, 8'h02);
      rdc(UMC_OFF_SHIFT, 8'h01);
      rdc(UMC_OFF_STATUS, 8'h01);
      wr(UMC_OFF_CTRL, 8'h00);
      rdc(UMC_OFF_SHIFT, 8'h01);
      // three-wire
      wr(UMC_OFF_SHIFT, 8'h80);
      wr(UMC_OFF_CTRL, 8'h10);
      settle();
      cb(pb_drv.dout[1], 1'b1);
      wr(UMC_OFF_PB_DIR, 8'h00);
      wr(UMC_OFF_PB_OUT, 8'h02);
      settle();
      cb(pb_drv.pull[1], 1'b1);
      cb(pb_drv.oe[1], 1'b0);
      wr(UMC_OFF_PB_DIR, 8'h02);
      // timer compare source, transparent latch
      wr(UMC_OFF_STATUS, 8'h00);
      wr(UMC_OFF_CTRL, 8'h14);
      tc0_match <= 1'b1;
      @(posedge sys_clk);
      tc0_match <= 1'b0;
      settle();
      cb(pb_drv.dout[1], 1'b0);
      rdc(UMC_OFF_SHIFT, 8'h01);
      rdc(UMC_OFF_STATUS, 8'h01);
      // external clock: rising, falling, toggle-counted
      wr(UMC_OFF_SHIFT, 8'h80);
      wr(UMC_OFF_STATUS, 8'h00);
      wr(UMC_OFF_CTRL, 8'h18);
      i_peer_b.line(2, 1'b1);
      settle();
      cb(pb_drv.dout[1], 1'b1);
      i_peer_b.line(2, 1'b0);
      settle();
      cb(pb_drv.dout[1], 1'b0);
      rdc(UMC_OFF_SHIFT, 8'h01);
      rdc(UMC_OFF_STATUS, 8'h02);
      wr(UMC_OFF_CTRL, 8'h1C);
      i_peer_b.clk_pulse();
      settle();
      rdc(UMC_OFF_SHIFT, 8'h03);
      rdc(UMC_OFF_STATUS, 8'h04);
      wr(UMC_OFF_CTRL, 8'h1A);
      i_peer_b.clk_pulse();
      settle();
      rdc(UMC_OFF_SHIFT, 8'h07);
      rdc(UMC_OFF_STATUS, 8'h04);
      wr(UMC_OFF_CTRL, 8'h1B);
      rdc(UMC_OFF_STATUS, 8'h05);
      rdc(UMC_OFF_PB_OUT, 8'h06);
      rdc(UMC_OFF_CTRL, 8'h18);
      // counter wrap
      wr(UMC_OFF_CTRL, 8'h00);
      wr(UMC_OFF_STATUS, 8'h0F);
      wr(UMC_OFF_CTRL, 8'h02);
      rdc(UMC_OFF_STATUS, 8'h40);
      wr(UMC_OFF_STATUS, 8'h40);
      rdc(UMC_OFF_STATUS, 8'h00);
      // two-wire: open-drain SDA and SCL
      i_peer_b.line(2, 1'b1);
      wr(UMC_OFF_SHIFT, 8'h80);
      wr(UMC_OFF_PB_OUT, 8'h05);
      wr(UMC_OFF_PB_DIR, 8'h05);
      wr(UMC_OFF_CTRL, 8'h20);
      settle();
      cb(pb_drv.pull[0], 1'b0);
      cb(pb_drv.pull[2], 1'b0);
      cb(pb_drv.oe[0], 1'b0);
      cb(pb_drv.oe[2], 1'b0);
      wr(UMC_OFF_PB_OUT, 8'h01);
      settle();
      cb(pb_drv.oe[2], 1'b1);
      wr(UMC_OFF_SHIFT, 8'h00);
      settle();
      cb(pb_drv.oe[0], 1'b1);
      cb(pb_drv.dout[0], 1'b0);
      wr(UMC_OFF_SHIFT, 8'h80);
      wr(UMC_OFF_PB_OUT, 8'h05);
      settle();
      i_peer_b.line(0, 1'b0);
      settle();
      rdc(UMC_OFF_STATUS, 8'h90);
      cb(pb_drv.oe[2], 1'b1);
      i_peer_b.line(0, 1'b1);
      wr(UMC_OFF_STATUS, 8'h80);
      settle();
      cb(pb_drv.oe[2], 1'b0);
      rdc(UMC_OFF_STATUS, 8'h00);
      // overflow hold only in mode 11
      wr(UMC_OFF_SHIFT, 8'hC0);
      wr(UMC_OFF_STATUS, 8'h0F);
      wr(UMC_OFF_CTRL, 8'h22);
      settle();
      cb(pb_drv.oe[2], 1'b0);
      wr(UMC_OFF_CTRL, 8'h30);
      settle();
      cb(pb_drv.oe[2], 1'b1);
      wr(UMC_OFF_STATUS, 8'h40);
      settle();
      cb(pb_drv.oe[2], 1'b0);
      // pin position moves functions to port A
      wr(UMC_OFF_CTRL, 8'h10);
      wr(UMC_OFF_SHIFT, 8'h80);
      wr(UMC_OFF_PA_DIR, 8'h02);
      wr(UMC_OFF_PA_OUT, 8'h00);
      wr(UMC_OFF_PINPOS, 8'h01);
      settle();
      cb(pa_drv.dout[1], 1'b1);
      cb(pb_drv.dout[1], 1'b0);
      rdc(UMC_OFF_PINPOS, 8'h01);
      conclude();
   end
endmodule : usi_mode_clock_control_tb_top
